/* File: rcal_pkg.sv */
/*
  Constants, types and register map of the calendar and calibration
  register block of a real-time clock.
  Assumes a byte-wide register port and a 25 MHz system clock.
*/
package rcal_pkg;

  // ----------------------------------------------------------------
  // Widths and clock
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 25_000_000;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int DIV_W = 24;
  localparam int MAG_W = 6;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_FORMAT = 8'h01;
  localparam logic [ADDR_W-1:0] OFS_CAL_CTRL = 8'h02;
  localparam logic [ADDR_W-1:0] OFS_CAL_OUT = 8'h03;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_SEC = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_MIN = 8'h11;
  localparam logic [ADDR_W-1:0] OFS_HOUR = 8'h12;
  localparam logic [ADDR_W-1:0] OFS_WDAY = 8'h13;
  localparam logic [ADDR_W-1:0] OFS_MDAY = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_MON = 8'h15;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int CAL_SIGN_BIT = 7;
  localparam int CAL_MAG_LSB = 0;
  localparam int FMT_BIT = 7;
  localparam int PIN_BIT = 0;
  localparam logic CAL_SIGN_RST = 1'b0;
  localparam logic [MAG_W-1:0] CAL_MAG_RST = 6'h00;
  localparam logic [1:0] CAL_FSEL_RST = 2'h0;
  localparam logic FMT_RST = 1'b0;

  // ----------------------------------------------------------------
  // Readable bit masks per layout
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] SEC_BIN_MASK = 8'h3F;
  localparam logic [DATA_W-1:0] SEC_BCD_MASK = 8'h7F;
  localparam logic [DATA_W-1:0] MIN_BIN_MASK = 8'h3F;
  localparam logic [DATA_W-1:0] MIN_BCD_MASK = 8'h7F;
  localparam logic [DATA_W-1:0] HOUR_BIN_MASK = 8'h1F;
  localparam logic [DATA_W-1:0] HOUR_BCD_MASK = 8'h3F;
  localparam logic [DATA_W-1:0] WDAY_MASK = 8'h07;
  localparam logic [DATA_W-1:0] MDAY_BIN_MASK = 8'h1F;
  localparam logic [DATA_W-1:0] MDAY_BCD_MASK = 8'h3F;
  localparam logic [DATA_W-1:0] MON_BIN_MASK = 8'h0F;
  localparam logic [DATA_W-1:0] MON_BCD_MASK = 8'h1F;

  // ----------------------------------------------------------------
  // Calibration output timing
  // ----------------------------------------------------------------
  localparam int FREQ_HI_HZ = 512;
  localparam int FREQ_MID_HZ = 256;
  localparam int FREQ_LO_HZ = 1;
  localparam int HALF_HI_CYC = CLK_HZ / (2 * FREQ_HI_HZ);
  localparam int HALF_MID_CYC = CLK_HZ / (2 * FREQ_MID_HZ);
  localparam int HALF_LO_CYC = CLK_HZ / (2 * FREQ_LO_HZ);
  localparam int PPM_UP = 4;
  localparam int PPM_DOWN = 2;
  // Multiply before dividing so the step is not truncated twice
  localparam int STEP_UP_CYC = HALF_LO_CYC * PPM_UP / 1_000_000;
  localparam int STEP_DOWN_CYC = HALF_LO_CYC * PPM_DOWN / 1_000_000;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    RCAL_FSEL_OFF = 2'h0,
    RCAL_FSEL_HI = 2'h1,
    RCAL_FSEL_MID = 2'h2,
    RCAL_FSEL_LO = 2'h3
  } rcal_fsel_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } rcal_bus_req_t;

endpackage

/* File: rcal_rst_sync.sv */
/*
  Reset release synchroniser: asserts at once, releases after two edges.
  Assumes an active-low asynchronous reset input.
*/
`timescale 1ns/10ps
module rcal_rst_sync
(
  // Clock and raw reset
  input wire logic clk_in,
  input wire logic arst_n_in,
  // Synchronised reset
  output logic rst_n_out
);

  logic meta_reg;
  logic sync_reg;

  // Two stages so release never lands near an edge of the block logic
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
    end
    else
    begin
      meta_reg <= 1'b1;
      sync_reg <= meta_reg;
    end
  end

  assign rst_n_out = sync_reg;

endmodule

/* File: rcal_div.sv */
/*
  Toggle divider: flips its output every limit_in cycles while run_in.
  Assumes limit_in is at least one; stopped divider rests low.
*/
`timescale 1ns/10ps
module rcal_div
#(
  parameter int W = 24
)
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Control
  input wire logic run_in,
  input wire logic [W-1:0] limit_in,
  // Square wave
  output logic wave_out
);

  logic [W-1:0] cnt_reg;
  logic wave_reg;
  logic wrap;

  // Wrap test uses >= so a shrinking limit cannot strand the counter
  assign wrap = (cnt_reg >= (limit_in - W'(1)));

  // Half-period counter
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      cnt_reg <= '0;
      wave_reg <= 1'b0;
    end
    else if (!run_in)
    begin
      cnt_reg <= '0;
      wave_reg <= 1'b0;
    end
    else if (wrap)
    begin
      cnt_reg <= '0;
      wave_reg <= ~wave_reg;
    end
    else
    begin
      cnt_reg <= cnt_reg + W'(1);
    end
  end

  assign wave_out = wave_reg;

endmodule

/* File: rcal_regs_top.sv */
/*
  Calendar and calibration register block of a real-time clock.
  Holds the calibration trim, the calibration clock output select,
  the decimal format select and the six calendar count registers.
  Assumes a byte register port: one-cycle read and write strobes,
  read data valid in the cycle after the read strobe only.
  Counting of the calendar itself lives elsewhere in the unit.
*/
// Our own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/10ps
module rcal_regs_top
#(
  parameter int HALF_HI_P = rcal_pkg::HALF_HI_CYC,
  parameter int HALF_MID_P = rcal_pkg::HALF_MID_CYC,
  parameter int HALF_LO_P = rcal_pkg::HALF_LO_CYC
)
(
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic arst_n_in,
  // Register port
  input wire rcal_pkg::rcal_bus_req_t bus_req_in,
  output logic [rcal_pkg::DATA_W-1:0] rd_data_out,
  // Calibration trim towards the oscillator
  output logic calibration_sign_out,
  output logic [rcal_pkg::MAG_W-1:0] calibration_magnitude_out,
  // Layout select shared with the control part
  output logic decimal_format_select_out,
  // Calibration clock pin
  output logic cal_clock_out_pin_out
);

  import rcal_pkg::*;

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_n;

  rcal_rst_sync u_rst_sync
  (
    .clk_in(sys_clk_in),
    .arst_n_in(arst_n_in),
    .rst_n_out(rst_n)
  );

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic cal_sign_reg;
  logic [MAG_W-1:0] cal_mag_reg;
  rcal_fsel_t cal_fsel_reg;
  logic fmt_reg;
  logic [DATA_W-1:0] sec_reg;
  logic [DATA_W-1:0] min_reg;
  logic [DATA_W-1:0] hour_reg;
  logic [DATA_W-1:0] wday_reg;
  logic [DATA_W-1:0] mday_reg;
  logic [DATA_W-1:0] mon_reg;
  logic [DATA_W-1:0] rd_data_reg;
  logic [DATA_W-1:0] rd_data_next;
  logic cal_pin_reg;
  logic cal_pin_next;

  logic wr;
  logic rd;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;

  logic hit_format;
  logic hit_cal_ctrl;
  logic hit_cal_out;
  logic hit_status;
  logic hit_sec;
  logic hit_min;
  logic hit_hour;
  logic hit_wday;
  logic hit_mday;
  logic hit_mon;

  logic [DATA_W-1:0] sec_mask;
  logic [DATA_W-1:0] min_mask;
  logic [DATA_W-1:0] hour_mask;
  logic [DATA_W-1:0] mday_mask;
  logic [DATA_W-1:0] mon_mask;

  logic [DIV_W-1:0] half_hi;
  logic [DIV_W-1:0] half_mid;
  logic [DIV_W-1:0] half_lo;
  logic [DIV_W-1:0] trim_cyc;
  logic [DIV_W-1:0] trim_up_cyc;
  logic [DIV_W-1:0] trim_down_cyc;
  logic wave_hi;
  logic wave_mid;
  logic wave_lo;
  logic run_hi;
  logic run_mid;
  logic run_lo;

  logic [DATA_W-1:0] cal_ctrl_view;
  logic [DATA_W-1:0] cal_out_view;
  logic [DATA_W-1:0] format_view;
  logic [DATA_W-1:0] status_view;

  // ----------------------------------------------------------------
  // Bus request unpacking
  // ----------------------------------------------------------------
  assign wr = bus_req_in.wr;
  assign rd = bus_req_in.rd;
  assign addr = bus_req_in.addr;
  assign wdata = bus_req_in.wdata;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  // One compare per register; unmapped offsets hit nothing
  assign hit_format = (addr == OFS_FORMAT);
  assign hit_cal_ctrl = (addr == OFS_CAL_CTRL);
  assign hit_cal_out = (addr == OFS_CAL_OUT);
  assign hit_status = (addr == OFS_STATUS);
  assign hit_sec = (addr == OFS_SEC);
  assign hit_min = (addr == OFS_MIN);
  assign hit_hour = (addr == OFS_HOUR);
  assign hit_wday = (addr == OFS_WDAY);
  assign hit_mday = (addr == OFS_MDAY);
  assign hit_mon = (addr == OFS_MON);

  // ----------------------------------------------------------------
  // Layout masks
  // ----------------------------------------------------------------
  // The stored byte is filtered on write and again on read, so that
  // switching layout never exposes a bit the new layout keeps at zero
  assign sec_mask = fmt_reg ? SEC_BCD_MASK : SEC_BIN_MASK;
  assign min_mask = fmt_reg ? MIN_BCD_MASK : MIN_BIN_MASK;
  assign hour_mask = fmt_reg ? HOUR_BCD_MASK : HOUR_BIN_MASK;
  assign mday_mask = fmt_reg ? MDAY_BCD_MASK : MDAY_BIN_MASK;
  assign mon_mask = fmt_reg ? MON_BCD_MASK : MON_BIN_MASK;

  // ----------------------------------------------------------------
  // Calibration control register
  // ----------------------------------------------------------------
  // Sign and magnitude clear on reset; bit 6 is not stored at all
  always_ff @(posedge sys_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cal_sign_reg <= CAL_SIGN_RST;
      cal_mag_reg <= CAL_MAG_RST;
    end
    else if (wr && hit_cal_ctrl)
    begin
      cal_sign_reg <= wdata[CAL_SIGN_BIT];
      cal_mag_reg <= wdata[CAL_MAG_LSB +: MAG_W];
    end
  end

  // ----------------------------------------------------------------
  // Calibration output select register
  // ----------------------------------------------------------------
  // Only the two select bits are stored; bits 7-2 have no flop
  always_ff @(posedge sys_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cal_fsel_reg <= rcal_fsel_t'(CAL_FSEL_RST);
    end
    else if (wr && hit_cal_out)
    begin
      cal_fsel_reg <= rcal_fsel_t'(wdata[1:0]);
    end
  end

  // ----------------------------------------------------------------
  // Format select register
  // ----------------------------------------------------------------
  // Binary layout after reset until software asks for decimal
  always_ff @(posedge sys_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fmt_reg <= FMT_RST;
    end
    else if (wr && hit_format)
    begin
      fmt_reg <= wdata[FMT_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Calendar count registers
  // ----------------------------------------------------------------
  // No reset here on purpose: the calendar must survive a reset of
  // the bus side, so its contents stay undefined until written
  always_ff @(posedge sys_clk_in)
  begin
    if (wr && hit_sec)
    begin
      sec_reg <= wdata & sec_mask;
    end
  end

  // Minutes
  always_ff @(posedge sys_clk_in)
  begin
    if (wr && hit_min)
    begin
      min_reg <= wdata & min_mask;
    end
  end

  // Hours
  always_ff @(posedge sys_clk_in)
  begin
    if (wr && hit_hour)
    begin
      hour_reg <= wdata & hour_mask;
    end
  end

  // Weekday keeps one layout in both formats
  always_ff @(posedge sys_clk_in)
  begin
    if (wr && hit_wday)
    begin
      wday_reg <= wdata & WDAY_MASK;
    end
  end

  // Day of month
  always_ff @(posedge sys_clk_in)
  begin
    if (wr && hit_mday)
    begin
      mday_reg <= wdata & mday_mask;
    end
  end

  // Month
  always_ff @(posedge sys_clk_in)
  begin
    if (wr && hit_mon)
    begin
      mon_reg <= wdata & mon_mask;
    end
  end

  // ----------------------------------------------------------------
  // Read views
  // ----------------------------------------------------------------
  // Reserved positions are tied to zero in the views
  assign cal_ctrl_view = {cal_sign_reg, 1'b0, cal_mag_reg};
  assign cal_out_view = {6'h00, cal_fsel_reg};
  assign format_view = {fmt_reg, 7'h00};
  assign status_view = {7'h00, cal_pin_reg};

  // ----------------------------------------------------------------
  // Read data select
  // ----------------------------------------------------------------
  // Unmapped offsets read as zero; a cycle without read strobe
  // also yields zero so the data stand for one cycle only
  always_comb
  begin
    rd_data_next = 8'h00;
    if (!rd)
    begin
      rd_data_next = 8'h00;
    end
    else if (hit_format)
    begin
      rd_data_next = format_view;
    end
    else if (hit_cal_ctrl)
    begin
      rd_data_next = cal_ctrl_view;
    end
    else if (hit_cal_out)
    begin
      rd_data_next = cal_out_view;
    end
    else if (hit_status)
    begin
      rd_data_next = status_view;
    end
    else if (hit_sec)
    begin
      rd_data_next = sec_reg & sec_mask;
    end
    else if (hit_min)
    begin
      rd_data_next = min_reg & min_mask;
    end
    else if (hit_hour)
    begin
      rd_data_next = hour_reg & hour_mask;
    end
    else if (hit_wday)
    begin
      rd_data_next = wday_reg & WDAY_MASK;
    end
    else if (hit_mday)
    begin
      rd_data_next = mday_reg & mday_mask;
    end
    else if (hit_mon)
    begin
      rd_data_next = mon_reg & mon_mask;
    end
  end

  // Read data register
  always_ff @(posedge sys_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_data_reg <= 8'h00;
    end
    else
    begin
      rd_data_reg <= rd_data_next;
    end
  end

  // ----------------------------------------------------------------
  // Calibrated half period of the slow output
  // ----------------------------------------------------------------
  // Trimming up shortens the period, trimming down lengthens it.
  // Step sizes are rounded to whole clocks, so the ppm is approximate.
  assign half_hi = DIV_W'(HALF_HI_P);
  assign half_mid = DIV_W'(HALF_MID_P);
  assign half_lo = DIV_W'(HALF_LO_P);
  assign trim_up_cyc = DIV_W'(cal_mag_reg) * DIV_W'(STEP_UP_CYC);
  assign trim_down_cyc = DIV_W'(cal_mag_reg) * DIV_W'(STEP_DOWN_CYC);
  assign trim_cyc = cal_sign_reg ? (half_lo - trim_up_cyc)
                                 : (half_lo + trim_down_cyc);

  // ----------------------------------------------------------------
  // Calibration frequency dividers
  // ----------------------------------------------------------------
  // Only the selected divider runs; the others rest low
  assign run_hi = (cal_fsel_reg == RCAL_FSEL_HI);
  assign run_mid = (cal_fsel_reg == RCAL_FSEL_MID);
  assign run_lo = (cal_fsel_reg == RCAL_FSEL_LO);

  rcal_div #(.W(DIV_W)) u_div_hi
  (
    .clk_in(sys_clk_in),
    .rst_n_in(rst_n),
    .run_in(run_hi),
    .limit_in(half_hi),
    .wave_out(wave_hi)
  );

  rcal_div #(.W(DIV_W)) u_div_mid
  (
    .clk_in(sys_clk_in),
    .rst_n_in(rst_n),
    .run_in(run_mid),
    .limit_in(half_mid),
    .wave_out(wave_mid)
  );

  rcal_div #(.W(DIV_W)) u_div_lo
  (
    .clk_in(sys_clk_in),
    .rst_n_in(rst_n),
    .run_in(run_lo),
    .limit_in(trim_cyc),
    .wave_out(wave_lo)
  );

  // ----------------------------------------------------------------
  // Calibration pin
  // ----------------------------------------------------------------
  // Select off holds the pin low
  always_comb
  begin
    case (cal_fsel_reg)
      RCAL_FSEL_HI: cal_pin_next = wave_hi;
      RCAL_FSEL_MID: cal_pin_next = wave_mid;
      RCAL_FSEL_LO: cal_pin_next = wave_lo;
      default: cal_pin_next = 1'b0;
    endcase
  end

  // Registered so the pin is glitch free across select changes
  always_ff @(posedge sys_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cal_pin_reg <= 1'b0;
    end
    else
    begin
      cal_pin_reg <= cal_pin_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign rd_data_out = rd_data_reg;
  assign calibration_sign_out = cal_sign_reg;
  assign calibration_magnitude_out = cal_mag_reg;
  assign decimal_format_select_out = fmt_reg;
  assign cal_clock_out_pin_out = cal_pin_reg;

endmodule

/* File: rcal_regs_sva.sv */
/*
  Checker for the calendar and calibration register block.
  Assumes it is bound to rcal_regs_top and sees only its ports.
*/
`timescale 1ns/10ps
module rcal_regs_sva
  import rcal_pkg::*;
#(
  parameter int HALF_HI_P = 8,
  parameter int HALF_MID_P = 16,
  parameter int HALF_LO_P = 4000
)
(
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic arst_n_in,
  // Register port
  input wire rcal_pkg::rcal_bus_req_t bus_req_in,
  input wire logic [rcal_pkg::DATA_W-1:0] rd_data_out,
  // Watched outputs
  input wire logic calibration_sign_out,
  input wire logic [rcal_pkg::MAG_W-1:0] calibration_magnitude_out,
  input wire logic decimal_format_select_out,
  input wire logic cal_clock_out_pin_out
);
  // ------------------------------------------------------------
  // Pin run tracking
  // ------------------------------------------------------------
  logic [1:0] sel_reg;
  logic [1:0] togs_reg;
  logic pin_d_reg;
  int run_reg;
  int half_exp;
  wire cfg_wr = bus_req_in.wr && (bus_req_in.addr == OFS_CAL_OUT || bus_req_in.addr == OFS_CAL_CTRL);
  wire pin_chg = cal_clock_out_pin_out != pin_d_reg;
  // Only the 1 Hz output follows the trim
  assign half_exp = (sel_reg == 2'h1) ? HALF_HI_P : (sel_reg == 2'h2) ? HALF_MID_P :
    calibration_sign_out ? HALF_LO_P - STEP_UP_CYC * int'(calibration_magnitude_out) :
    HALF_LO_P + STEP_DOWN_CYC * int'(calibration_magnitude_out);
  // Two toggles after a change are needed: the restart may cut the first run short
  always_ff @(posedge sys_clk_in or negedge arst_n_in)
    if (!arst_n_in)
    begin
      sel_reg <= 2'h0;
      togs_reg <= 2'h0;
      pin_d_reg <= 1'b0;
      run_reg <= 0;
    end
    else
    begin
      pin_d_reg <= cal_clock_out_pin_out;
      run_reg <= pin_chg ? 1 : run_reg + 1;
      if (bus_req_in.wr && bus_req_in.addr == OFS_CAL_OUT)
        sel_reg <= bus_req_in.wdata[1:0];
      if (cfg_wr)
        togs_reg <= 2'h0;
      else if (pin_chg && togs_reg != 2'h3)
        togs_reg <= togs_reg + 2'h1;
    end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!arst_n_in);
  property mask_p(logic [7:0] ofs, logic [7:0] bin_m, logic [7:0] bcd_m);
    bus_req_in.rd && bus_req_in.addr == ofs |=>
      (rd_data_out & ~(decimal_format_select_out ? bcd_m : bin_m)) == 8'h00;
  endproperty
  cal_ctrl_read_a: assert property (bus_req_in.rd && bus_req_in.addr == OFS_CAL_CTRL |=>
    rd_data_out == {calibration_sign_out, 1'b0, calibration_magnitude_out}) else $error("trim read wrong");
  cal_ctrl_write_a: assert property (bus_req_in.wr && bus_req_in.addr == OFS_CAL_CTRL |=>
    calibration_sign_out == $past(bus_req_in.wdata[7]) && calibration_magnitude_out == $past(bus_req_in.wdata[5:0]))
    else $error("trim not stored");
  cal_out_read_a: assert property (bus_req_in.rd && bus_req_in.addr == OFS_CAL_OUT |=>
    rd_data_out == {6'h00, sel_reg}) else $error("output select read wrong");
  sec_mask_a: assert property (mask_p(OFS_SEC, 8'h3F, 8'h7F)) else $error("seconds high bits set");
  min_mask_a: assert property (mask_p(OFS_MIN, 8'h3F, 8'h7F)) else $error("minutes high bits set");
  hour_mask_a: assert property (mask_p(OFS_HOUR, 8'h1F, 8'h3F)) else $error("hours high bits set");
  wday_mask_a: assert property (mask_p(OFS_WDAY, 8'h07, 8'h07)) else $error("weekday high bits set");
  mday_mask_a: assert property (mask_p(OFS_MDAY, 8'h1F, 8'h3F)) else $error("month day high bits set");
  mon_mask_a: assert property (mask_p(OFS_MON, 8'h0F, 8'h1F)) else $error("month high bits set");
  fmt_write_a: assert property (bus_req_in.wr && bus_req_in.addr == OFS_FORMAT |=>
    decimal_format_select_out == $past(bus_req_in.wdata[7])) else $error("format not stored");
  pin_off_a: assert property ((sel_reg == 2'h0) [*3] |-> !cal_clock_out_pin_out) else $error("pin not idle");
  pin_half_a: assert property (pin_chg && togs_reg[1] |-> run_reg == half_exp) else $error("half period wrong");
  cal_read_c: cover property (bus_req_in.rd && bus_req_in.addr == OFS_CAL_CTRL);
  bcd_sec_c: cover property (decimal_format_select_out && bus_req_in.rd && bus_req_in.addr == OFS_SEC);
  lo_toggle_c: cover property (sel_reg == 2'h3 && pin_chg && togs_reg[1]);
endmodule

bind rcal_regs_top rcal_regs_sva #(
  .HALF_HI_P(HALF_HI_P),
  .HALF_MID_P(HALF_MID_P),
  .HALF_LO_P(HALF_LO_P)
) rcal_regs_sva_inst (
  .sys_clk_in(sys_clk_in),
  .arst_n_in(arst_n_in),
  .bus_req_in(bus_req_in),
  .rd_data_out(rd_data_out),
  .calibration_sign_out(calibration_sign_out),
  .calibration_magnitude_out(calibration_magnitude_out),
  .decimal_format_select_out(decimal_format_select_out),
  .cal_clock_out_pin_out(cal_clock_out_pin_out)
);

/* File: rcal_regs_top_tb.sv */
/*
  Self-checking bench for the calendar and calibration register block.
  Assumes rcal_pkg and the checker are compiled before it.
*/
`timescale 1ns/10ps
module rcal_regs_top_tb;
  import rcal_pkg::*;
  // Short dividers keep the 1 Hz runs brief
  localparam int HI = 8;
  localparam int MID = 16;
  localparam int LO = 4000;
  logic sys_clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  rcal_bus_req_t bus_req = '0;
  logic [7:0] rd_data;
  logic sign;
  logic [5:0] mag;
  logic fmt;
  logic pin;
  int bad_count = 0;
  int checked = 0;
  int n;
  logic [7:0] bin_m [6] = '{8'h3F, 8'h3F, 8'h1F, 8'h07, 8'h1F, 8'h0F};
  logic [7:0] bcd_m [6] = '{8'h7F, 8'h7F, 8'h3F, 8'h07, 8'h3F, 8'h1F};

  always #20 sys_clk_in = ~sys_clk_in;

  rcal_regs_top #(.HALF_HI_P(HI), .HALF_MID_P(MID), .HALF_LO_P(LO)) rcal_regs_top_inst (
    .sys_clk_in(sys_clk_in),
    .arst_n_in(arst_n_in),
    .bus_req_in(bus_req),
    .rd_data_out(rd_data),
    .calibration_sign_out(sign),
    .calibration_magnitude_out(mag),
    .decimal_format_select_out(fmt),
    .cal_clock_out_pin_out(pin)
  );

  // ------------------------------------------------------------
  // Bus and check tasks
  // ------------------------------------------------------------
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_in);
    bus_req <= '{1'b1, 1'b0, a, d};
    @(posedge sys_clk_in);
    bus_req <= '0;
  endtask

  // Read data stand one cycle only, so they are taken at the next falling edge
  task automatic bus_rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(posedge sys_clk_in);
    bus_req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge sys_clk_in);
    bus_req <= '0;
    @(negedge sys_clk_in);
    chk(what, 16'(exp), 16'(rd_data));
  endtask

  // The third run is whole; the first two may be cut by the restart
  task automatic half(input int exp, input string what);
    logic p;
    for (int k = 0; k < 3; k++)
    begin
      n = 0;
      p = pin;
      while (pin === p && n < 9000)
      begin
        @(negedge sys_clk_in);
        n++;
      end
    end
    chk(what, 16'(exp), 16'(n));
  endtask

  task automatic do_reset;
    arst_n_in <= 1'b0;
    repeat (5) @(posedge sys_clk_in);
    arst_n_in <= 1'b1;
    repeat (3) @(posedge sys_clk_in);
  endtask

  task automatic stop_test;
    $display("Comparisons %0d, mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial
  begin
    do_reset;
    bus_rd(OFS_CAL_CTRL, 8'h00, "trim at reset");
    bus_rd(OFS_CAL_OUT, 8'h00, "select at reset");
    bus_rd(OFS_FORMAT, 8'h00, "format at reset");
    bus_wr(OFS_CAL_CTRL, 8'hFF);
    bus_rd(OFS_CAL_CTRL, 8'hBF, "trim");
    chk("sign", 16'(1), 16'(sign));
    chk("magnitude", 16'h3F, 16'(mag));
    bus_wr(OFS_CAL_CTRL, 8'h40);
    bus_rd(OFS_CAL_CTRL, 8'h00, "trim reserved");
    bus_wr(OFS_CAL_OUT, 8'hFE);
    bus_rd(OFS_CAL_OUT, 8'h02, "select");
    bus_wr(8'h20, 8'h5A);
    bus_rd(8'h20, 8'h00, "unmapped");
    // Every calendar register in both layouts, all ones written
    for (int f = 0; f < 2; f++)
    begin
      bus_wr(OFS_FORMAT, f ? 8'h80 : 8'h00);
      @(negedge sys_clk_in);
      chk("format", 16'(f), 16'(fmt));
      for (int r = 0; r < 6; r++)
      begin
        bus_wr(8'(OFS_SEC + r), 8'hFF);
        bus_rd(8'(OFS_SEC + r), f ? bcd_m[r] : bin_m[r], "calendar");
      end
    end
    bus_wr(OFS_SEC, 8'h59);
    bus_rd(OFS_SEC, 8'h59, "decimal seconds");
    bus_wr(OFS_FORMAT, 8'h00);
    bus_rd(OFS_SEC, 8'h19, "binary view");
    bus_wr(OFS_SEC, 8'h2A);
    bus_wr(OFS_CAL_CTRL, 8'h8A);
    do_reset;
    bus_rd(OFS_CAL_CTRL, 8'h00, "trim cleared");
    bus_rd(OFS_SEC, 8'h2A, "seconds kept");
    bus_wr(OFS_CAL_OUT, 8'h01);
    half(HI, "512 Hz half");
    bus_wr(OFS_CAL_OUT, 8'h02);
    half(MID, "256 Hz half");
    bus_wr(OFS_CAL_CTRL, 8'h8A);
    bus_wr(OFS_CAL_OUT, 8'h03);
    half(LO - 10 * STEP_UP_CYC, "1 Hz trimmed up");
    bus_wr(OFS_CAL_CTRL, 8'h0A);
    half(LO + 10 * STEP_DOWN_CYC, "1 Hz trimmed down");
    bus_wr(OFS_CAL_OUT, 8'h00);
    repeat (3) @(negedge sys_clk_in);
    n = 0;
    repeat (40)
    begin
      @(negedge sys_clk_in);
      n += pin;
    end
    chk("pin idle", 16'(0), 16'(n));
    bus_rd(OFS_STATUS, 8'h00, "status idle");
    stop_test;
  end

  // Watchdog: the tests need under 24000 cycles
  initial
  begin
    #(40 * 60000);
    bad_count++;
    stop_test;
  end
endmodule
